// ### psw_pkg.sv
// Constants for the program space data window block.
// Assumes a 16-bit data path, 24-bit program words and an APB register port.
package psw_pkg;
   // Register indexes; byte address is four times the index
   localparam logic [11:0] PSW_IDX_TABLE_PAGE = 12'h032;
   localparam logic [11:0] PSW_IDX_WINDOW_PAGE = 12'h034;
   localparam logic [11:0] PSW_IDX_CORE_CONTROL = 12'h044;
   localparam logic [11:0] PSW_IDX_STATUS = 12'h046;
   localparam int PSW_BYTES_PER_REG = 4;
   // Reset values
   localparam logic [15:0] PSW_RST_TABLE_PAGE = 16'h0000;
   localparam logic [15:0] PSW_RST_WINDOW_PAGE = 16'h0000;
   localparam logic [15:0] PSW_RST_CORE_CONTROL = 16'h0000;
   // Field positions and masks
   localparam int PSW_WIN_EN_BIT = 2;
   localparam logic [15:0] PSW_CORE_CONTROL_WMASK = 16'h1fff;
   localparam int PSW_EA_SEL_BIT = 15;
   localparam logic [15:0] PSW_WINDOW_BASE = 16'h8000;
   // Extra instruction cycles per windowed access
   localparam logic [1:0] PSW_EXTRA_FULL = 2'h2;
   localparam logic [1:0] PSW_EXTRA_MOVE = 2'h1;
   localparam logic [1:0] PSW_EXTRA_NONE = 2'h0;
   // Access engine states
   typedef enum logic [1:0] {
      PSW_IDLE = 2'b00,
      PSW_DATA = 2'b01,
      PSW_PROG = 2'b10
   } psw_state_t;
endpackage

// ### psw_page_reg.sv
// Page pointer register: low byte stored, upper byte reads zero.
// Assumes a single-cycle write strobe from the register port.
`timescale 1ns/10ps
`default_nettype none
module psw_page_reg #(
   parameter logic [15:0] RST_VAL = 16'h0000
) (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic wr_en,
   input wire logic [7:0] wr_data,
   output logic [15:0] value
);
   logic [7:0] page_reg;

   // Low byte store, synchronous reset
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         page_reg <= RST_VAL[7:0];
      end else if (wr_en) begin
         page_reg <= wr_data;
      end
   end

   // RULE8 upper byte zero
   assign value = {8'h00, page_reg};
endmodule
`default_nettype wire

// ### psw_window.sv
// Program space data window: redirects high data addresses onto the program bus.
// Assumes memories return read data in the same cycle as their request strobe,
// and a CPU that holds off a new access until the done pulse.
//
// Function
// RULE1 - Windowed operand fetch adds two instruction cycles normally.
// RULE2 - Move instructions through the window add only one cycle.
// RULE3 - Added cycles are spent fetching on the program memory bus.
// RULE4 - Middle repeat-loop iterations add no cycles.
// RULE5 - First and last repeat iterations add two cycles.
// RULE6 - Iteration before interrupt exit of repeat adds two cycles.
// RULE7 - First iteration resuming repeat after interrupt adds two cycles.
// RULE8 - Both page pointers keep low byte only, upper zero, reset zero.
// RULE9 - Self programming uses table writes; serial programming is external.
// RULE10 - Window works only while core control bit 2 is set.
// RULE11 - Addresses at or above 0x8000 go to program memory when enabled.
// RULE12 - Program address is page byte joined to fifteen low address bits.
// RULE13 - Window returns low 16 bits; address bit 0 selects byte.
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
module psw_window (
   input wire logic sys_clk,
   input wire logic sys_rst,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // CPU data access request
   input wire logic cpu_req,
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_byte,
   input wire logic cpu_is_move,
   input wire logic cpu_in_repeat,
   input wire logic cpu_rep_first,
   input wire logic cpu_rep_last,
   input wire logic cpu_irq_exit,
   input wire logic cpu_rep_resume,
   output logic [15:0] cpu_rdata,
   output logic cpu_done,
   output logic cpu_busy,
   // Data memory bus
   output logic dm_req,
   output logic [15:0] dm_addr,
   input wire logic [15:0] dm_rdata,
   // Program memory read bus
   output logic pm_req,
   output logic [22:0] pm_addr,
   input wire logic [23:0] pm_rdata,
   // Table write instruction and program write bus
   input wire logic tbl_wr_req,
   input wire logic [15:0] tbl_wr_addr,
   input wire logic [15:0] tbl_wr_data,
   input wire logic tbl_wr_high,
   output logic pm_wr_req,
   output logic [22:0] pm_wr_addr,
   output logic [15:0] pm_wr_data,
   output logic pm_wr_high
);
   import psw_pkg::*;

   psw_state_t state_reg;
   logic [15:0] core_control_reg;
   logic [15:0] table_page;
   logic [15:0] window_page;
   logic [1:0] extra_reg;
   logic [1:0] extra_next;
   logic byte_reg;
   logic lo_sel_reg;
   logic last_win_reg;
   logic [1:0] last_extra_reg;
   logic [11:0] reg_idx;
   logic addr_ok;
   logic setup;
   logic wr_hit;
   logic win_hit;
   logic rep_middle;
   logic [31:0] rd_mux;
   logic [15:0] pm_word;
   logic take;
   logic finish;

   // Register index decode: byte address is four times the index
   assign reg_idx = paddr[13:2];
   assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[15:14] == 2'h0) &&
      ((reg_idx == PSW_IDX_TABLE_PAGE) || (reg_idx == PSW_IDX_WINDOW_PAGE) ||
       (reg_idx == PSW_IDX_CORE_CONTROL) || (reg_idx == PSW_IDX_STATUS));
   assign setup = psel && !penable;
   assign wr_hit = psel && penable && pready && pwrite && addr_ok;

   // One wait-free access phase; ready and error come from flops
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup && !addr_ok;
      end
   end

   // Read data captured in the setup cycle, zero outside the access phase
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         prdata <= 32'h0000_0000;
      end else begin
         prdata <= (setup && !pwrite && addr_ok) ? rd_mux : 32'h0000_0000;
      end
   end

   // Read multiplexer
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (reg_idx)
         PSW_IDX_TABLE_PAGE: rd_mux = {16'h0000, table_page};
         PSW_IDX_WINDOW_PAGE: rd_mux = {16'h0000, window_page};
         PSW_IDX_CORE_CONTROL: rd_mux = {16'h0000, core_control_reg};
         PSW_IDX_STATUS: rd_mux = {28'h0000000, last_extra_reg, last_win_reg, cpu_busy};
         default: rd_mux = 32'h0000_0000;
      endcase
   end

   // RULE8 page pointers
   psw_page_reg #(.RST_VAL(PSW_RST_TABLE_PAGE)) u_table_page (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .wr_en(wr_hit && (reg_idx == PSW_IDX_TABLE_PAGE)),
      .wr_data(pwdata[7:0]),
      .value(table_page)
   );
   psw_page_reg #(.RST_VAL(PSW_RST_WINDOW_PAGE)) u_window_page (
      .sys_clk(sys_clk),
      .sys_rst(sys_rst),
      .wr_en(wr_hit && (reg_idx == PSW_IDX_WINDOW_PAGE)),
      .wr_data(pwdata[7:0]),
      .value(window_page)
   );

   // Core control register; top three bits unimplemented
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         core_control_reg <= PSW_RST_CORE_CONTROL;
      end else if (wr_hit && (reg_idx == PSW_IDX_CORE_CONTROL)) begin
         core_control_reg <= pwdata[15:0] & PSW_CORE_CONTROL_WMASK;
      end
   end

   // RULE10 RULE11 window decode
   assign win_hit = core_control_reg[PSW_WIN_EN_BIT] && (cpu_addr >= PSW_WINDOW_BASE);

   // RULE4 middle iteration test
   assign rep_middle = cpu_in_repeat && !cpu_rep_first && !cpu_rep_last &&
      !cpu_irq_exit && !cpu_rep_resume;

   // Extra cycle cost of a windowed access
   always_comb begin
      extra_next = PSW_EXTRA_FULL; // RULE1 two extra cycles
      if (rep_middle) begin
         // RULE4 no overhead
         extra_next = PSW_EXTRA_NONE;
      end else if (cpu_is_move && !cpu_in_repeat) begin
         // RULE2 move costs one
         extra_next = PSW_EXTRA_MOVE;
      end
      // RULE5 RULE6 RULE7 full cost otherwise
   end

   // RULE13 low word, byte select
   assign pm_word = pm_rdata[15:0];

   // Access accepted, and last cycle of the access in progress
   assign take = (state_reg == PSW_IDLE) && cpu_req;
   assign finish = (state_reg == PSW_DATA) ||
      ((state_reg == PSW_PROG) && (extra_reg == 2'h0));

   // Access sequencing
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         state_reg <= PSW_IDLE;
      end else begin
         case (state_reg)
            PSW_IDLE: begin
               if (cpu_req && win_hit) begin
                  // RULE3 fetch on program bus
                  state_reg <= PSW_PROG;
               end else if (cpu_req) begin
                  // RULE11 low addresses to data memory
                  state_reg <= PSW_DATA;
               end
            end
            PSW_DATA: begin
               state_reg <= PSW_IDLE;
            end
            PSW_PROG: begin
               if (extra_reg == 2'h0) begin
                  state_reg <= PSW_IDLE;
               end
            end
            default: begin
               state_reg <= PSW_IDLE;
            end
         endcase
      end
   end

   // Added cycle counter, loaded with the cost of a windowed access
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         extra_reg <= 2'h0;
      end else if (take && win_hit) begin
         extra_reg <= extra_next;
      end else if ((state_reg == PSW_PROG) && (extra_reg != 2'h0)) begin
         extra_reg <= extra_reg - 2'h1;
      end
   end

   // Byte mode and byte lane captured at the take
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         byte_reg <= 1'b0;
         lo_sel_reg <= 1'b0;
      end else if (take) begin
         byte_reg <= cpu_byte;
         lo_sel_reg <= cpu_addr[0];
      end
   end

   // Data memory request, one cycle long
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         dm_req <= 1'b0;
         dm_addr <= 16'h0000;
      end else begin
         dm_req <= take && !win_hit;
         if (take && !win_hit) begin
            dm_addr <= cpu_addr;
         end
      end
   end

   // RULE3 program bus held while counting
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pm_req <= 1'b0;
         pm_addr <= 23'h000000;
      end else if (take && win_hit) begin
         pm_req <= 1'b1;
         // RULE12 page joined to low bits
         pm_addr <= {window_page[7:0], cpu_addr[PSW_EA_SEL_BIT-1:0]};
      end else if ((state_reg != PSW_PROG) || (extra_reg == 2'h0)) begin
         pm_req <= 1'b0;
      end
   end

   // Done pulse and busy level; a stray state code drops busy
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cpu_done <= 1'b0;
         cpu_busy <= 1'b0;
      end else begin
         cpu_done <= finish;
         cpu_busy <= take || ((state_reg == PSW_PROG) && (extra_reg != 2'h0));
      end
   end

   // Read data returned to the core, held until the next done
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         cpu_rdata <= 16'h0000;
      end else if (state_reg == PSW_DATA) begin
         cpu_rdata <= !byte_reg ? dm_rdata :
            (lo_sel_reg ? {8'h00, dm_rdata[15:8]} : {8'h00, dm_rdata[7:0]});
      end else if ((state_reg == PSW_PROG) && (extra_reg == 2'h0)) begin
         // RULE13 byte select
         cpu_rdata <= !byte_reg ? pm_word :
            (lo_sel_reg ? {8'h00, pm_word[15:8]} : {8'h00, pm_word[7:0]});
      end
   end

   // Status of the last access taken
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         last_win_reg <= 1'b0;
         last_extra_reg <= 2'h0;
      end else if (take) begin
         last_win_reg <= win_hit;
         last_extra_reg <= win_hit ? extra_next : PSW_EXTRA_NONE;
      end
   end

   // RULE9 table writes drive program programming
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         pm_wr_req <= 1'b0;
         pm_wr_addr <= 23'h000000;
         pm_wr_data <= 16'h0000;
         pm_wr_high <= 1'b0;
      end else begin
         pm_wr_req <= tbl_wr_req;
         if (tbl_wr_req) begin
            pm_wr_addr <= {table_page[7:0], tbl_wr_addr[PSW_EA_SEL_BIT:1]};
            pm_wr_data <= tbl_wr_data;
            pm_wr_high <= tbl_wr_high;
         end
      end
   end
endmodule
`default_nettype wire

// ### psw_window_sva.sv
// Checker for the program space data window top ports.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module psw_window_sva (
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [15:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic cpu_req,
   input wire logic [15:0] cpu_addr,
   input wire logic cpu_is_move,
   input wire logic cpu_in_repeat,
   input wire logic cpu_rep_first,
   input wire logic cpu_rep_last,
   input wire logic cpu_irq_exit,
   input wire logic cpu_rep_resume,
   input wire logic cpu_done,
   input wire logic cpu_busy,
   input wire logic dm_req,
   input wire logic pm_req,
   input wire logic [22:0] pm_addr,
   input wire logic tbl_wr_req,
   input wire logic [15:0] tbl_wr_addr,
   input wire logic pm_wr_req,
   input wire logic [22:0] pm_wr_addr
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   // Access taken, and any repeat boundary flag
   wire tk = cpu_req && !cpu_busy;
   wire edg = cpu_rep_first || cpu_rep_last || cpu_irq_exit || cpu_rep_resume;
   a_full_cost: assert property (tk && !cpu_is_move && !cpu_in_repeat ##1 pm_req
      |-> pm_req[*3] ##1 (cpu_done && !pm_req)) else $error("full cost wrong");
   a_move_cost: assert property (tk && cpu_is_move && !cpu_in_repeat ##1 pm_req
      |-> pm_req[*2] ##1 cpu_done) else $error("move cost wrong");
   a_prog_bus: assert property (pm_req |-> !dm_req && cpu_busy)
      else $error("fetch not on program bus");
   a_rep_mid: assert property (tk && cpu_in_repeat && !edg ##1 pm_req
      |-> ##1 cpu_done) else $error("repeat middle cost wrong");
   a_rep_edge: assert property (tk && cpu_in_repeat && edg ##1 pm_req
      |-> pm_req[*3] ##1 cpu_done) else $error("repeat edge cost wrong");
   a_low_data: assert property (tk && !cpu_addr[15] |=> dm_req && !pm_req ##1 cpu_done)
      else $error("low address not data memory");
   a_page_addr: assert property ($rose(pm_req) |-> pm_addr[14:0] == $past(cpu_addr[14:0]))
      else $error("program address low bits wrong");
   a_page_upper: assert property (psel && penable && pready && !pwrite
      && (paddr == 16'h00c8 || paddr == 16'h00d0) |-> prdata[31:8] == 24'h0)
      else $error("page upper byte not zero");
   a_tbl_write: assert property (tbl_wr_req
      |=> pm_wr_req && pm_wr_addr[14:0] == $past(tbl_wr_addr[15:1])) else $error("table write lost");
   a_apb_ready: assert property (psel && !penable |=> pready) else $error("no ready");
endmodule
bind psw_window psw_window_sva psw_window_sva_inst (.*);
`default_nettype wire

// ### psw_mem_model.sv
// Data and program memories answering in the cycle of their request.
// Assumes the window drives one request at a time; idle buses show junk.
`timescale 1ns/10ps
`default_nettype none
module psw_mem_model (
   input wire logic sys_clk,
   input wire logic dm_req,
   input wire logic [15:0] dm_addr,
   input wire logic pm_req,
   input wire logic [22:0] pm_addr,
   output logic [15:0] dm_rdata,
   output logic [23:0] pm_rdata
);
   logic [23:0] junk = 24'h000001;
   // Junk that changes every cycle on released buses
   always @(posedge sys_clk) junk <= {junk[22:0], ~junk[23]};
   // full 24-bit word, address coded in its value
   assign pm_rdata = pm_req ? {pm_addr[22:15], {pm_addr[15:1], 1'b0} ^ {pm_addr[22:15], 8'h5a}}
      : junk;
   assign dm_rdata = dm_req ? {dm_addr[15:1], 1'b0} ^ 16'h1234 : junk[15:0];
endmodule
`default_nettype wire

// ### psw_window_tb_top.sv
// Testbench for the program space data window: APB registers and CPU accesses.
// Assumes the memory model answers in the request cycle.
`timescale 1ns/10ps
`default_nettype none
module psw_window_tb_top;
   logic sys_clk, sys_rst, psel, penable, pwrite, pready, pslverr, cpu_req, cpu_byte;
   logic cpu_is_move, cpu_in_repeat, cpu_rep_first, cpu_rep_last, cpu_irq_exit, cpu_rep_resume;
   logic cpu_done, cpu_busy, dm_req, pm_req, tbl_wr_req, tbl_wr_high, pm_wr_req, pm_wr_high;
   logic [15:0] paddr, cpu_addr, cpu_rdata, dm_addr, dm_rdata, tbl_wr_addr, tbl_wr_data, pm_wr_data;
   logic [31:0] pwdata, prdata;
   logic [22:0] pm_addr, pm_wr_addr;
   logic [23:0] pm_rdata;
   int bad_count = 0, n_compared = 0, cyc = 0;
   localparam logic [7:0] PG = 8'h81;
   psw_window psw_window_inst (.*);
   psw_mem_model psw_mem_model_inst (.*);
   // Clock
   initial begin
      sys_clk = 0;
      forever #5 sys_clk = ~sys_clk;
   end
   task chk(input logic ok, input string m);
      n_compared++;
      if (ok !== 1'b1) begin
         bad_count++;
         $display("ERROR %0t %s", $time, m);
      end
   endtask
   task test_done;
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task apb(input logic w, input logic [15:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge sys_clk);
      psel <= 1;
      penable <= 0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1;
      do begin
         @(posedge sys_clk);
      end while (pready !== 1'b1);
      r = prdata;
      chk(pslverr === (a == 16'h00f0), "slave error");
      psel <= 0;
      penable <= 0;
   endtask
   task wr(input logic [15:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask
   task rd(input logic [15:0] a, input logic [31:0] x);
      logic [31:0] r;
      apb(1'b0, a, 32'h0, r);
      chk(r === x, "read data");
   endtask
   // Expected read: window or data word, then byte select
   function automatic logic [15:0] ex(input logic w, input logic [15:0] a, input logic b);
      logic [15:0] v;
      v = w ? {PG[0], a[14:1], 1'b0} ^ {PG, 8'h5a} : {a[15:1], 1'b0} ^ 16'h1234;
      ex = b ? {8'h00, a[0] ? v[15:8] : v[7:0]} : v;
   endfunction
   // f: byte, move, repeat, first, last, irq exit, resume
   task cpu(input logic [15:0] a, input logic [6:0] f, input logic w, input int x);
      int n, pc;
      cpu_addr <= a;
      {cpu_byte, cpu_is_move, cpu_in_repeat, cpu_rep_first, cpu_rep_last, cpu_irq_exit,
         cpu_rep_resume} <= f;
      cpu_req <= 1;
      @(posedge sys_clk);
      cpu_req <= 0;
      n = 0;
      pc = 0;
      do begin
         @(posedge sys_clk);
         n++;
         pc += int'(pm_req === 1'b1);
      end while (cpu_done !== 1'b1 && n < 20);
      chk(n == x + 2 && pc == (w ? x + 1 : 0), "access cycles");
      chk(cpu_rdata === ex(w, a, f[6]), "access data");
   endtask
   // Hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 2000) begin
         bad_count++;
         test_done;
      end
   end
   initial begin
      {sys_rst, psel, penable, pwrite, paddr, pwdata, cpu_req, cpu_addr} <= {1'b1, 68'h0};
      {cpu_byte, cpu_is_move, cpu_in_repeat, cpu_rep_first, cpu_rep_last} <= 5'h0;
      {cpu_irq_exit, cpu_rep_resume, tbl_wr_req, tbl_wr_addr, tbl_wr_data, tbl_wr_high} <= 36'h0;
      repeat (4) @(posedge sys_clk);
      sys_rst <= 0;
      rd(16'h00c8, 32'h0);
      rd(16'h00d0, 32'h0);
      rd(16'h0110, 32'h0);
      rd(16'h00f0, 32'h0);
      wr(16'h00c8, 32'hffffffff);
      rd(16'h00c8, 32'h000000ff);
      wr(16'h00d0, {24'h000012, PG});
      rd(16'h00d0, {24'h0, PG});
      $display("test registers done");
      cpu(16'h9000, 7'h00, 1'b0, 0);
      wr(16'h0110, 32'h00000004);
      rd(16'h0110, 32'h00000004);
      cpu(16'h7ffe, 7'h00, 1'b0, 0);
      cpu(16'h8000, 7'h00, 1'b1, 2);
      rd(16'h0118, 32'h0000000a);
      cpu(16'hfffe, 7'h20, 1'b1, 1);
      cpu(16'h8a42, 7'h10, 1'b1, 0);
      for (int i = 0; i < 4; i++)
         cpu(16'h8100, 7'h30 | (7'h08 >> i), 1'b1, 2);
      cpu(16'h8003, 7'h40, 1'b1, 2);
      cpu(16'h0101, 7'h40, 1'b0, 0);
      $display("test accesses done");
      tbl_wr_addr <= 16'h2468;
      tbl_wr_data <= 16'hbeef;
      tbl_wr_high <= 1;
      tbl_wr_req <= 1;
      @(posedge sys_clk);
      tbl_wr_req <= 0;
      @(posedge sys_clk);
      chk(pm_wr_req === 1'b1 && pm_wr_addr === 23'h7f9234 && pm_wr_data === 16'hbeef, "tbl");
      chk(pm_wr_high === 1'b1, "table write half");
      $display("test table write done");
      sys_rst <= 1;
      repeat (2) @(posedge sys_clk);
      sys_rst <= 0;
      rd(16'h00c8, 32'h0);
      rd(16'h00d0, 32'h0);
      rd(16'h0110, 32'h0);
      $display("test reset done");
      test_done;
   end
endmodule
`default_nettype wire
